// [hdl/audio_clk_consts.vh]
`ifndef AUDIO_CLK_CONSTS_VH
`define AUDIO_CLK_CONSTS_VH
// register offsets
`define OFS_P1_BCLK_CTRL 12'h500
`define OFS_P1_MODE 12'h501
`define OFS_P1_STATUS 12'h502
`define OFS_P1_FRAME_LEN 12'h506
`define OFS_P2_BCLK_CTRL 12'h540
`define OFS_P2_MODE 12'h541
`define OFS_P2_STATUS 12'h542
`define OFS_P2_FRAME_LEN 12'h546
// reset values
`define RST_BCLK_SEL 5'h0C
`define RST_FRAME_LEN 13'h0040
`define RST_RATE_SEL 4'h0
`define RST_MASTER 1'b0
// field positions inside the mode register
`define MODE_RATE_MSB 3
`define MODE_MASTER_BIT 8
// bit clock select codes
`define SEL_FIRST_VALID 5'h02
`define SEL_TOP 5'h12
// rate selector threshold for the secondary domain
`define RATE_SEC_MIN 4'h8
// sample rate pattern of the 44.1 kHz family (01XXX)
`define FAM44_PATTERN 2'b01
// clock rate and base bit clock rates in Hz
`define CLK_HZ 27'd10000000
`define BASE48_EVEN_HZ 26'd64000
`define BASE48_ODD_HZ 26'd96000
`define BASE44_EVEN_HZ 26'd58800
`define BASE44_ODD_HZ 26'd88200
`endif

// [hdl/audio_port_bit_frame_clock_gen.v]
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "audio_clk_consts.vh"

////////////////////////////////////////////////////////////////////////////
// one port: rate lookup, bit clock oscillator, frame divider
module port_clock_unit (
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire [4:0] bit_clock_rate_select,
  input wire [12:0] cycles_per_frame,
  input wire [3:0] port_rate_selector,
  input wire master,
  input wire [4:0] sys_rate_1,
  input wire [4:0] sys_rate_2,
  input wire [4:0] sys_rate_3,
  input wire [4:0] secondary_sample_rate_setting_1,
  input wire [4:0] secondary_sample_rate_setting_2,
  input wire bclk_in,
  input wire frame_in,
  output wire bclk_out,
  output wire bclk_oe,
  output wire frame_out,
  output wire frame_oe,
  output wire [3:0] status
);
  reg [4:0] gov_rate;
  reg use_secondary;
  reg fam44;
  reg [25:0] step;
  reg [3:0] shamt;
  reg [25:0] base;
  reg [25:0] acc_ff;
  reg [26:0] sum;
  reg [26:0] diff;
  reg [25:0] nxt_acc;
  reg toggle;
  reg bclk_ff;
  reg frame_ff;
  reg [12:0] bit_cnt_ff;
  reg [1:0] bclk_sync_ff;
  reg [1:0] frame_sync_ff;

  // pick the domain and its governing sample rate setting
  always @* begin
    use_secondary = (port_rate_selector >= `RATE_SEC_MIN);
    if (use_secondary) begin
      gov_rate = port_rate_selector[0] ? secondary_sample_rate_setting_2 :
                 secondary_sample_rate_setting_1;
    end else begin
      case (port_rate_selector[1:0])
        2'b00: gov_rate = sys_rate_1;
        2'b01: gov_rate = sys_rate_2;
        default: gov_rate = sys_rate_3;
      endcase
    end
    fam44 = (gov_rate[4:3] == `FAM44_PATTERN);
  end

  // twice the bit clock rate in Hz; even codes double from the 64 kHz base (58.8 kHz in the 44.1 kHz family),
  // odd ones from 96 kHz (88.2 kHz), and the top code jumps one octave further
  always @* begin
    shamt = 4'h0;
    base = fam44 ? `BASE44_EVEN_HZ : `BASE48_EVEN_HZ;
    if (bit_clock_rate_select == `SEL_TOP) begin
      base = fam44 ? `BASE44_ODD_HZ : `BASE48_ODD_HZ;
      shamt = 4'h8;
    end else if (bit_clock_rate_select[0]) begin
      base = fam44 ? `BASE44_ODD_HZ : `BASE48_ODD_HZ;
      shamt = bit_clock_rate_select[4:1] - 4'h1;
    end else begin
      shamt = bit_clock_rate_select[4:1] - 4'h1;
    end
    // codes below the first valid one halt the bit clock
    if (bit_clock_rate_select < `SEL_FIRST_VALID) begin
      step = 26'h0000000;
    end else begin
      step = base << (shamt + 4'h1);
    end
  end

  // phase accumulator: one half period elapses per wrap of the modulus
  always @* begin
    sum = {1'b0, acc_ff} + {1'b0, step};
    diff = sum - `CLK_HZ;
    toggle = (sum >= `CLK_HZ);
    nxt_acc = sum[25:0];
    if (toggle)
      nxt_acc = (diff >= `CLK_HZ) ? 26'h0000000 : diff[25:0];
  end

  // bit clock and frame divider; a rate above half the clock saturates at
  // one toggle per cycle, which is as close as this clock can get
  always @(posedge clk_sys) begin
    if (!rstn) begin
      acc_ff <= 26'h0000000;
      bclk_ff <= 1'b0;
      frame_ff <= 1'b0;
      bit_cnt_ff <= 13'h0000;
    end else if (ce) begin
      if (!master) begin
        acc_ff <= 26'h0000000;
        bclk_ff <= 1'b0;
        frame_ff <= 1'b0;
        bit_cnt_ff <= 13'h0000;
      end else begin
        acc_ff <= nxt_acc;
        if (toggle) begin
          bclk_ff <= ~bclk_ff;
          // frame moves only on a falling bit clock edge
          if (bclk_ff) begin
            if (bit_cnt_ff >= cycles_per_frame - 13'h0001) begin
              bit_cnt_ff <= 13'h0000;
              frame_ff <= 1'b1;
            end else begin
              bit_cnt_ff <= bit_cnt_ff + 13'h0001;
              if (bit_cnt_ff + 13'h0001 == {1'b0, cycles_per_frame[12:1]})
                frame_ff <= 1'b0;
            end
          end
        end
      end
    end
  end

  // pin levels from the far side cross into this clock
  always @(posedge clk_sys) begin
    if (!rstn) begin
      bclk_sync_ff <= 2'b00;
      frame_sync_ff <= 2'b00;
    end else if (ce) begin
      bclk_sync_ff <= {bclk_sync_ff[0], bclk_in};
      frame_sync_ff <= {frame_sync_ff[0], frame_in};
    end
  end

  assign bclk_out = bclk_ff;
  assign frame_out = frame_ff;
  assign bclk_oe = master;
  assign frame_oe = master;
  assign status = {use_secondary, fam44,
                   master ? frame_ff : frame_sync_ff[1],
                   master ? bclk_ff : bclk_sync_ff[1]};
endmodule

////////////////////////////////////////////////////////////////////////////
// register file and the two ports
module audio_port_bit_frame_clock_gen (
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire [11:0] addr,
  input wire [15:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rd_data,
  input wire [4:0] sys_rate_1,
  input wire [4:0] sys_rate_2,
  input wire [4:0] sys_rate_3,
  input wire [4:0] secondary_sample_rate_setting_1,
  input wire [4:0] secondary_sample_rate_setting_2,
  input wire p1_bclk_in,
  output wire p1_bclk_out,
  output wire p1_bclk_oe,
  input wire p1_frame_in,
  output wire p1_frame_out,
  output wire p1_frame_oe,
  input wire p2_bclk_in,
  output wire p2_bclk_out,
  output wire p2_bclk_oe,
  input wire p2_frame_in,
  output wire p2_frame_out,
  output wire p2_frame_oe
);
  reg [4:0] p1_sel_ff;
  reg [4:0] p2_sel_ff;
  reg [12:0] p1_len_ff;
  reg [12:0] p2_len_ff;
  reg [3:0] p1_rate_ff;
  reg [3:0] p2_rate_ff;
  reg p1_master_ff;
  reg p2_master_ff;
  reg [15:0] nxt_rd;
  wire [3:0] p1_status;
  wire [3:0] p2_status;

  // register writes; each port owns a separate set
  always @(posedge clk_sys) begin
    if (!rstn) begin
      p1_sel_ff <= `RST_BCLK_SEL;
      p2_sel_ff <= `RST_BCLK_SEL;
      p1_len_ff <= `RST_FRAME_LEN;
      p2_len_ff <= `RST_FRAME_LEN;
      p1_rate_ff <= `RST_RATE_SEL;
      p2_rate_ff <= `RST_RATE_SEL;
      p1_master_ff <= `RST_MASTER;
      p2_master_ff <= `RST_MASTER;
    end else if (ce && wr_en) begin
      case (addr)
        `OFS_P1_BCLK_CTRL: p1_sel_ff <= wr_data[4:0];
        `OFS_P2_BCLK_CTRL: p2_sel_ff <= wr_data[4:0];
        `OFS_P1_FRAME_LEN: p1_len_ff <= wr_data[12:0];
        `OFS_P2_FRAME_LEN: p2_len_ff <= wr_data[12:0];
        `OFS_P1_MODE: begin
          p1_rate_ff <= wr_data[`MODE_RATE_MSB:0];
          p1_master_ff <= wr_data[`MODE_MASTER_BIT];
        end
        `OFS_P2_MODE: begin
          p2_rate_ff <= wr_data[`MODE_RATE_MSB:0];
          p2_master_ff <= wr_data[`MODE_MASTER_BIT];
        end
        default: ;
      endcase
    end
  end

  // read decode; unmapped addresses answer zero
  always @* begin
    case (addr)
      `OFS_P1_BCLK_CTRL: nxt_rd = {11'h000, p1_sel_ff};
      `OFS_P2_BCLK_CTRL: nxt_rd = {11'h000, p2_sel_ff};
      `OFS_P1_FRAME_LEN: nxt_rd = {3'h0, p1_len_ff};
      `OFS_P2_FRAME_LEN: nxt_rd = {3'h0, p2_len_ff};
      `OFS_P1_MODE: nxt_rd = {7'h00, p1_master_ff, 4'h0, p1_rate_ff};
      `OFS_P2_MODE: nxt_rd = {7'h00, p2_master_ff, 4'h0, p2_rate_ff};
      `OFS_P1_STATUS: nxt_rd = {12'h000, p1_status};
      `OFS_P2_STATUS: nxt_rd = {12'h000, p2_status};
      default: nxt_rd = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= rd_en ? nxt_rd : 16'h0000;
    end
  end

  port_clock_unit port1 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .bit_clock_rate_select(p1_sel_ff),
    .cycles_per_frame(p1_len_ff),
    .port_rate_selector(p1_rate_ff),
    .master(p1_master_ff),
    .sys_rate_1(sys_rate_1),
    .sys_rate_2(sys_rate_2),
    .sys_rate_3(sys_rate_3),
    .secondary_sample_rate_setting_1(secondary_sample_rate_setting_1),
    .secondary_sample_rate_setting_2(secondary_sample_rate_setting_2),
    .bclk_in(p1_bclk_in),
    .frame_in(p1_frame_in),
    .bclk_out(p1_bclk_out),
    .bclk_oe(p1_bclk_oe),
    .frame_out(p1_frame_out),
    .frame_oe(p1_frame_oe),
    .status(p1_status)
  );

  port_clock_unit port2 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .bit_clock_rate_select(p2_sel_ff),
    .cycles_per_frame(p2_len_ff),
    .port_rate_selector(p2_rate_ff),
    .master(p2_master_ff),
    .sys_rate_1(sys_rate_1),
    .sys_rate_2(sys_rate_2),
    .sys_rate_3(sys_rate_3),
    .secondary_sample_rate_setting_1(secondary_sample_rate_setting_1),
    .secondary_sample_rate_setting_2(secondary_sample_rate_setting_2),
    .bclk_in(p2_bclk_in),
    .frame_in(p2_frame_in),
    .bclk_out(p2_bclk_out),
    .bclk_oe(p2_bclk_oe),
    .frame_out(p2_frame_out),
    .frame_oe(p2_frame_oe),
    .status(p2_status)
  );
endmodule

// [sim/clk_gen_chk.sv]
`timescale 1ns/1ns
module clk_gen_chk (
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire [11:0] addr,
  input wire [15:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rd_data,
  input wire p1_bclk_out,
  input wire p1_bclk_oe,
  input wire p1_frame_out,
  input wire p1_frame_oe,
  input wire p2_bclk_out,
  input wire p2_bclk_oe,
  input wire p2_frame_out,
  input wire p2_frame_oe
);
  // shadow of the first select, so reads and clock activity tie to it
  reg [4:0] sel_ff;
  always @(posedge clk_sys) begin
    if (!rstn && ce)
      sel_ff <= 5'h0C;
    else if (ce && wr_en && addr == 12'h500)
      sel_ff <= wr_data[4:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  AST_RD_SEL: assert property (ce && rd_en && addr == 12'h500
    |=> rd_data == {11'h000, sel_ff}) else $error("select readback");
  AST_RST_SLAVE: assert property ($rose(rstn)
    |-> !p1_bclk_oe && !p2_bclk_oe) else $error("not slave after reset");
  AST_OE_PAIR1: assert property (p1_bclk_oe == p1_frame_oe)
    else $error("port 1 enables differ");
  AST_OE_PAIR2: assert property (p2_bclk_oe == p2_frame_oe)
    else $error("port 2 enables differ");
  AST_P1_QUIET: assert property (!p1_bclk_oe && !$past(p1_bclk_oe)
    |-> !p1_bclk_out && !p1_frame_out) else $error("port 1 slave drives");
  AST_P2_QUIET: assert property (!p2_bclk_oe && !$past(p2_bclk_oe)
    |-> !p2_bclk_out && !p2_frame_out) else $error("port 2 slave drives");
  AST_P1_FEDGE: assert property (p1_frame_oe && $past(p1_frame_oe)
    && $changed(p1_frame_out) |-> $fell(p1_bclk_out))
    else $error("port 1 frame off bit edge");
  AST_P2_FEDGE: assert property (p2_frame_oe && $past(p2_frame_oe)
    && $changed(p2_frame_out) |-> $fell(p2_bclk_out))
    else $error("port 2 frame off bit edge");
  // slowest code toggles about every 85 cycles
  AST_P1_RUNS: assert property (p1_bclk_oe && sel_ff >= 5'h02
    && sel_ff <= 5'h12 |-> ##[1:90] ($changed(p1_bclk_out) || !p1_bclk_oe))
    else $error("port 1 bit clock stuck");
  CV_P1_FRAME: cover property (p1_bclk_oe && $rose(p1_frame_out));
  CV_P2_FRAME: cover property (p2_bclk_oe && $rose(p2_frame_out));
  CV_STATUS: cover property (rd_en && addr == 12'h502);
endmodule
bind audio_port_bit_frame_clock_gen clk_gen_chk chk (
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .p1_bclk_out(p1_bclk_out), .p1_bclk_oe(p1_bclk_oe),
  .p1_frame_out(p1_frame_out), .p1_frame_oe(p1_frame_oe),
  .p2_bclk_out(p2_bclk_out), .p2_bclk_oe(p2_bclk_oe),
  .p2_frame_out(p2_frame_out), .p2_frame_oe(p2_frame_oe));

// [sim/host_serial_model.sv]
`timescale 1ns/1ns
module host_serial_model (
  input wire clk_sys,
  input wire run,
  output reg bclk,
  output reg frame
);
  reg [1:0] div_ff;
  reg [3:0] bit_ff;
  initial begin
    bclk = 1'b0;
    frame = 1'b0;
    div_ff = 2'h0;
    bit_ff = 4'h0;
  end
  // bit clock at a sixth of the system rate; both lines rest low when idle
  always @(posedge clk_sys) begin
    if (!run) begin
      div_ff <= 2'h0;
      bclk <= 1'b0;
      frame <= 1'b0;
    end else if (div_ff == 2'h2) begin
      div_ff <= 2'h0;
      bclk <= !bclk;
      if (bclk) begin
        bit_ff <= bit_ff + 4'h1;
        frame <= (bit_ff == 4'hF);
      end
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
endmodule

// [sim/audio_port_bit_frame_clock_gen_tb_top.sv]
`timescale 1ns/1ns
module audio_port_bit_frame_clock_gen_tb_top;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg ce = 1'b1;
  reg [11:0] addr = 12'h000;
  reg [15:0] wr_data = 16'h0000;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg [4:0] sys_rate_1 = 5'h08;
  reg [4:0] sys_rate_2 = 5'h10;
  reg [4:0] sys_rate_3 = 5'h0B;
  reg [4:0] sec_1 = 5'h0F;
  reg [4:0] sec_2 = 5'h12;
  reg run = 1'b0;
  reg psel = 1'b0;
  reg [15:0] d;
  integer error_cnt = 0;
  integer checks_done = 0;
  wire [15:0] rd_data;
  wire hb, hf, b1, o1, f1, g1, b2, o2, f2, g2;
  wire mb = psel ? b2 : b1;
  wire mf = psel ? f2 : f1;
  // 10 MHz system clock
  always #50 clk_sys = !clk_sys;
  host_serial_model host (.clk_sys(clk_sys), .run(run), .bclk(hb),
    .frame(hf));
  audio_port_bit_frame_clock_gen dut (.clk_sys(clk_sys), .rstn(rstn),
    .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .sys_rate_1(sys_rate_1), .sys_rate_2(sys_rate_2),
    .sys_rate_3(sys_rate_3), .secondary_sample_rate_setting_1(sec_1),
    .secondary_sample_rate_setting_2(sec_2), .p1_bclk_in(hb),
    .p1_bclk_out(b1), .p1_bclk_oe(o1), .p1_frame_in(hf), .p1_frame_out(f1),
    .p1_frame_oe(g1), .p2_bclk_in(hb), .p2_bclk_out(b2), .p2_bclk_oe(o2),
    .p2_frame_in(hf), .p2_frame_out(f2), .p2_frame_oe(g2));
  //////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input string what, input [15:0] exp, input [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %0s exp %h got %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task wr(input [11:0] a, input [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task rd(input [11:0] a, output [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  // counts bit clock falls and system cycles from one frame start to the
  // next; the accumulator phase lets the cycle count land on lo or hi
  task measure(input [15:0] exp, input [15:0] lo, input [15:0] hi);
    integer i;
    reg pb, pf, seen, done;
    reg [15:0] n, c;
    n = 16'h0000;
    c = 16'h0000;
    seen = 0;
    done = 0;
    pb = mb;
    pf = mf;
    for (i = 0; i < 4000 && !done; i++) begin
      @(negedge clk_sys);
      if (seen && pb && !mb) n++;
      if (seen) c++;
      if (!pf && mf) begin
        done = seen;
        seen = 1;
      end
      pb = mb;
      pf = mf;
    end
    if (!done) begin
      error_cnt++;
      summarize;
    end
    cmp("frame length", exp, n);
    cmp("frame cycles", (c == hi) ? hi : lo, c);
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(12'h500, d); cmp("p1 select", 16'h000C, d);
    rd(12'h506, d); cmp("p1 length", 16'h0040, d);
    rd(12'h540, d); cmp("p2 select", 16'h000C, d);
    rd(12'h546, d); cmp("p2 length", 16'h0040, d);
    rd(12'h503, d); cmp("unmapped", 16'h0000, d);
    $display("reset test done");
  endtask
  task t_regs;
    wr(12'h500, 16'hFFFF);
    rd(12'h500, d); cmp("select bits", 16'h001F, d);
    wr(12'h546, 16'h1FFF);
    rd(12'h546, d); cmp("p2 length", 16'h1FFF, d);
    rd(12'h506, d); cmp("p1 length kept", 16'h0040, d);
    wr(12'h500, 16'h000C);
    $display("register test done");
  endtask
  task t_family;
    reg [19:0] rt, et;
    integer i;
    rt = 20'h98210;
    et = 20'h8C404;
    for (i = 0; i < 5; i++) begin
      wr(12'h501, {12'h000, rt[i*4+:4]});
      rd(12'h502, d);
      cmp("domain", {12'h000, et[i*4+:4]}, d & 16'h000C);
    end
    $display("family test done");
  endtask
  // port 1 runs on rate 0 (44.1 kHz family), port 2 on rate 1 (48 kHz)
  task t_master(input p, input [4:0] code, input [15:0] len,
    input [15:0] lo, input [15:0] hi);
    psel = p;
    wr(p ? 12'h540 : 12'h500, {11'h000, code});
    wr(p ? 12'h546 : 12'h506, len);
    wr(p ? 12'h541 : 12'h501, p ? 16'h0101 : 16'h0100);
    measure(len, lo, hi);
    cmp("enables", p ? 16'h0003 : 16'h000C,
      {12'h000, o1, g1, o2, g2});
    wr(p ? 12'h541 : 12'h501, 16'h0000);
    $display("master test done");
  endtask
  task t_slave;
    integer i;
    reg seen;
    reg [1:0] lvl;
    seen = 0;
    lvl = 2'b00;
    wr(12'h500, 16'h000A);
    wr(12'h506, 16'h0008);
    run <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(negedge clk_sys);
      seen = seen | b1 | f1 | o1 | g1;
    end
    // 120 cycles span more than one 96-cycle host frame
    for (i = 0; i < 60; i++) begin
      rd(12'h502, d);
      lvl = lvl | d[1:0];
    end
    run <= 1'b0;
    cmp("slave quiet", 16'h0000, {15'h0000, seen});
    cmp("slave pin levels", 16'h0003, {14'h0000, lvl});
    repeat (4) @(posedge clk_sys);
    rd(12'h502, d);
    cmp("slave idle levels", 16'h0000, d & 16'h0003);
    $display("slave test done");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_regs;
    t_family;
    // 3.7632 MHz: 8 bits take 21.26 cycles of 100 ns
    t_master(1'b0, 5'h0E, 16'h0008, 16'h0015, 16'h0016);
    // 1.024 MHz: 16 bits take 156.25 cycles of 100 ns
    t_master(1'b1, 5'h0A, 16'h0010, 16'h009C, 16'h009D);
    t_slave;
    summarize;
  end
endmodule
